// ==== include/cnm_map.svh ====
/*
 Constants for the CAN node mode manager: mode codes, configuration
 selectors, reset values and timing counts.
 Assumes it is included by its bare name, ahead of the code that uses it.
*/
`default_nettype none
`ifndef CNM_MAP_SVH
`define CNM_MAP_SVH
// Mode request and mode status codes
`define CNM_MODE_NORMAL 3'h0
`define CNM_MODE_SLEEP 3'h1
`define CNM_MODE_LOOP 3'h2
`define CNM_MODE_LISTEN 3'h3
`define CNM_MODE_CONFIG 3'h4
// Protected configuration selectors
`define CNM_SEL_BTA 3'h0
`define CNM_SEL_BTB 3'h1
`define CNM_SEL_BTC 3'h2
`define CNM_SEL_SEND 3'h3
`define CNM_SEL_FILT 3'h4
`define CNM_SEL_MASK 3'h5
// Reset values
`define CNM_CFG_RST 8'h00
`define CNM_CNT_RST 8'h00
// Timing
`define CNM_REF_NS 50
`define CNM_OSCILLATOR_PERIOD_NS 50
`define CNM_OST_OSCILLATOR_PERIOD 128
`define CNM_OST_CYC \
    ((`CNM_OST_OSCILLATOR_PERIOD * `CNM_OSCILLATOR_PERIOD_NS + `CNM_REF_NS - 1) / `CNM_REF_NS)
`define CNM_LINK_NS 64
`define CNM_WUF_NS 500
`define CNM_WUF_CYC ((`CNM_WUF_NS + `CNM_LINK_NS - 1) / `CNM_LINK_NS)
`endif
`default_nettype wire

// ==== include/cnm_pkg.sv ====
/*
 Types for the CAN node mode manager: modes, configuration bytes and the
 state of the controller and link domains.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package cnm_pkg;

    typedef enum logic [2:0] {
        cnm_md_config,
        cnm_md_normal,
        cnm_md_sleep,
        cnm_md_listen,
        cnm_md_loop,
        cnm_md_wake
    } cnm_mode_e;

    typedef struct packed {
        logic [7:0] bt_a;
        logic [7:0] bt_b;
        logic [7:0] bt_c;
        logic [7:0] send_pin;
        logic [7:0] filter;
        logic [7:0] mask;
    } cnm_cfg_s;

    typedef struct packed {
        cnm_mode_e mode;
        logic hold_sleep;
        logic discard;
        logic [7:0] ost_cnt;
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        logic wake_flag;
        logic wake_irq;
        logic [7:0] tec;
        logic [7:0] rec;
        cnm_cfg_s cfg;
        logic can_tx;
        logic eng_rx;
        logic ack_en;
        logic err_en;
        logic ign_ack;
        logic store;
        logic [2:0] status;
        logic osc_en;
    } cnm_ctl_s;

    typedef struct packed {
        logic standby_select_pin_s1;
        logic standby_select_pin_s2;
        logic txd_s1;
        logic txd_s2;
        logic bus_s1;
        logic bus_s2;
        logic [3:0] filt_cnt;
        logic rxd;
        logic bus_tx;
    } cnm_lnk_s;

endpackage : cnm_pkg
`default_nettype wire

// ==== logic/cnm_mode_manager.sv ====
/*
 Mode manager of a CAN node: controller modes, sleep and wake-up with
 oscillator start-up, protected configuration, and the transceiver's
 normal and standby behaviour with its wake-up filter.
 Assumes host inputs are synchronous to ref_clk_in; bus and standby pin
 arrive asynchronously; bus_clk_in runs free.
*/
`include "cnm_map.svh"
`default_nettype none

// How it works
// - Standby pin low: transceiver drives bus and passes bus to rxd.
// - Standby pin high: driver off, low-power receiver with wake filter.
// - In standby rxd shows bus lows delayed by the wake filter; bus highs pass at once.
// - Reset or a config request puts the controller in config mode.
// - Entering config mode clears both error counters.
// - Timing, send-pin and filter writes land only in config mode.
// - Only normal mode transmits, acknowledges and sends error frames.
// - Status and registers stay readable while asleep.
// - Host polls mode status after sleep request; stays active until then.
// - Oscillator is stopped once sleep is entered.
// - Bus activity or host wake flag wakes; interrupt needs enable bit.
// - A falling receive edge in sleep counts as bus activity.
// - Standby rxd goes low on filtered activity; short noise rejected.
// - After wake wait 128 oscillator periods before receiving.
// - Drop the waking frame and start-up frames; resume in listen-only.
// - Listen-only transmits nothing, no acknowledge, no error flags.
// - Listen-only stores good and bad frames, ignoring filters.
// - Listen-only holds both error counters cleared.
// - Loopback feeds own frames internally and ignores acknowledge.
// - Loopback keeps the transmit output recessive.
// - Loopback still filters; an all-zero mask passes everything.
// - Mode change waits for pending transmits; status shows real mode.
module cnm_mode_manager #(
    parameter int OST_CYC = `CNM_OST_CYC,
    parameter int WUF_CYC = `CNM_WUF_CYC
) (
    input wire logic ref_clk_in,
    input wire logic bus_clk_in,
    input wire logic arst_n_in,
    input wire logic [2:0] mode_request_in,
    input wire logic tx_pending_in,
    input wire logic host_wake_in,
    input wire logic wake_flag_clr_in,
    input wire logic wake_interrupt_enable_in,
    input wire logic cfg_wr_in,
    input wire logic [2:0] cfg_sel_in,
    input wire logic [7:0] cfg_data_in,
    input wire logic engine_tx_in,
    input wire logic tec_inc_in,
    input wire logic rec_inc_in,
    input wire logic frame_done_in,
    input wire logic frame_error_in,
    input wire logic [7:0] frame_id_in,
    input wire logic standby_select_pin_in,
    input wire logic bus_rx_in,
    output logic [2:0] mode_status_out,
    output logic osc_enable_out,
    output logic wake_flag_out,
    output logic wake_irq_out,
    output logic [7:0] tec_out,
    output logic [7:0] rec_out,
    output cnm_pkg::cnm_cfg_s cfg_out,
    output logic controller_transmit_out,
    output logic engine_rx_out,
    output logic ack_enable_out,
    output logic err_frame_enable_out,
    output logic ignore_ack_out,
    output logic rx_store_out,
    output logic bus_tx_out,
    output logic rxd_out
);

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic cnm_pkg::cnm_mode_e req_decode(
        input logic [2:0] code,
        input cnm_pkg::cnm_mode_e cur
    );
        case (code)
            `CNM_MODE_NORMAL: req_decode = cnm_pkg::cnm_md_normal;
            `CNM_MODE_SLEEP: req_decode = cnm_pkg::cnm_md_sleep;
            `CNM_MODE_LOOP: req_decode = cnm_pkg::cnm_md_loop;
            `CNM_MODE_LISTEN: req_decode = cnm_pkg::cnm_md_listen;
            `CNM_MODE_CONFIG: req_decode = cnm_pkg::cnm_md_config;
            default: req_decode = cur;
        endcase
    endfunction : req_decode

    function automatic logic [2:0] mode_code(input cnm_pkg::cnm_mode_e m);
        case (m)
            cnm_pkg::cnm_md_normal: mode_code = `CNM_MODE_NORMAL;
            cnm_pkg::cnm_md_sleep: mode_code = `CNM_MODE_SLEEP;
            cnm_pkg::cnm_md_wake: mode_code = `CNM_MODE_SLEEP;
            cnm_pkg::cnm_md_loop: mode_code = `CNM_MODE_LOOP;
            cnm_pkg::cnm_md_listen: mode_code = `CNM_MODE_LISTEN;
            default: mode_code = `CNM_MODE_CONFIG;
        endcase
    endfunction : mode_code

    // Zero mask bits are don't-care
    function automatic logic accept(
        input logic [7:0] id,
        input logic [7:0] filt,
        input logic [7:0] mask
    );
        accept = ((id ^ filt) & mask) == 8'h00;
    endfunction : accept

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == 8'hff) ? v : v + 8'h01;
    endfunction : sat_inc

    ////////////////////////////////////////////////////////////////////
    // Controller domain

    localparam cnm_pkg::cnm_ctl_s CTL_RST = '{
        mode: cnm_pkg::cnm_md_config,
        rx_s1: 1'b1,
        rx_s2: 1'b1,
        rx_prev: 1'b1,
        can_tx: 1'b1,
        eng_rx: 1'b1,
        status: `CNM_MODE_CONFIG,
        osc_en: 1'b1,
        default: '0
    };

    cnm_pkg::cnm_ctl_s ctl_reg;
    cnm_pkg::cnm_ctl_s ctl_next;
    cnm_pkg::cnm_lnk_s lnk_reg;
    cnm_pkg::cnm_lnk_s lnk_next;
    cnm_pkg::cnm_mode_e req_mode;
    logic rx_fall;
    logic wake_ev;
    logic listen;

    always_comb begin
        ctl_next = ctl_reg;
        ctl_next.rx_s1 = lnk_reg.rxd;
        ctl_next.rx_s2 = ctl_reg.rx_s1;
        ctl_next.rx_prev = ctl_reg.rx_s2;
        rx_fall = ctl_reg.rx_prev & ~ctl_reg.rx_s2;
        req_mode = req_decode(mode_request_in, ctl_reg.mode);
        wake_ev = host_wake_in |
            (rx_fall & (ctl_reg.mode == cnm_pkg::cnm_md_sleep));
        case (ctl_reg.mode)
            cnm_pkg::cnm_md_sleep: begin
                if (wake_ev) begin
                    ctl_next.mode = cnm_pkg::cnm_md_wake;
                    ctl_next.ost_cnt = 8'h00;
                    ctl_next.discard = rx_fall;
                    ctl_next.hold_sleep = 1'b1;
                end
            end
            cnm_pkg::cnm_md_wake: begin
                if (ctl_reg.ost_cnt == 8'(OST_CYC - 1)) begin
                    ctl_next.mode = cnm_pkg::cnm_md_listen;
                end else begin
                    ctl_next.ost_cnt = ctl_reg.ost_cnt + 8'h01;
                end
            end
            default: begin
                if (mode_request_in != `CNM_MODE_SLEEP) begin
                    ctl_next.hold_sleep = 1'b0;
                end
                if (req_mode != ctl_reg.mode && !tx_pending_in &&
                    !(req_mode == cnm_pkg::cnm_md_sleep &&
                      ctl_reg.hold_sleep)) begin
                    ctl_next.mode = req_mode;
                end
            end
        endcase
        ctl_next.wake_flag = (ctl_reg.wake_flag & ~wake_flag_clr_in) |
            wake_ev;
        ctl_next.wake_irq = ctl_next.wake_flag &
            wake_interrupt_enable_in;
        listen = ctl_next.mode == cnm_pkg::cnm_md_listen;
        if (ctl_next.mode == cnm_pkg::cnm_md_config || listen) begin
            ctl_next.tec = `CNM_CNT_RST;
            ctl_next.rec = `CNM_CNT_RST;
        end else begin
            if (tec_inc_in) begin
                ctl_next.tec = sat_inc(ctl_reg.tec);
            end
            if (rec_inc_in) begin
                ctl_next.rec = sat_inc(ctl_reg.rec);
            end
        end
        if (cfg_wr_in && ctl_reg.mode == cnm_pkg::cnm_md_config) begin
            case (cfg_sel_in)
                `CNM_SEL_BTA: ctl_next.cfg.bt_a = cfg_data_in;
                `CNM_SEL_BTB: ctl_next.cfg.bt_b = cfg_data_in;
                `CNM_SEL_BTC: ctl_next.cfg.bt_c = cfg_data_in;
                `CNM_SEL_SEND: ctl_next.cfg.send_pin = cfg_data_in;
                `CNM_SEL_FILT: ctl_next.cfg.filter = cfg_data_in;
                `CNM_SEL_MASK: ctl_next.cfg.mask = cfg_data_in;
                default: ctl_next.cfg = ctl_reg.cfg;
            endcase
        end
        // Transmit path, silent outside normal mode
        ctl_next.can_tx = (ctl_next.mode == cnm_pkg::cnm_md_normal) ?
            engine_tx_in : 1'b1;
        ctl_next.ack_en = ctl_next.mode == cnm_pkg::cnm_md_normal;
        ctl_next.err_en = ctl_next.mode == cnm_pkg::cnm_md_normal;
        ctl_next.ign_ack = ctl_next.mode == cnm_pkg::cnm_md_loop;
        ctl_next.eng_rx = ctl_next.ign_ack ?
            engine_tx_in : ctl_reg.rx_s2;
        // Frame storage
        if (ctl_reg.discard && frame_done_in &&
            ctl_reg.mode != cnm_pkg::cnm_md_wake) begin
            ctl_next.discard = 1'b0;
        end
        case (ctl_reg.mode)
            cnm_pkg::cnm_md_listen: begin
                ctl_next.store = frame_done_in & ~ctl_reg.discard;
            end
            cnm_pkg::cnm_md_normal, cnm_pkg::cnm_md_loop: begin
                ctl_next.store = frame_done_in & ~frame_error_in &
                    ~ctl_reg.discard & accept(frame_id_in,
                    ctl_reg.cfg.filter, ctl_reg.cfg.mask);
            end
            default: ctl_next.store = 1'b0;
        endcase
        ctl_next.status = mode_code(ctl_next.mode);
        ctl_next.osc_en = ctl_next.mode != cnm_pkg::cnm_md_sleep;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctl_reg <= CTL_RST;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link domain: transceiver

    localparam cnm_pkg::cnm_lnk_s LNK_RST = '{
        txd_s1: 1'b1,
        txd_s2: 1'b1,
        bus_s1: 1'b1,
        bus_s2: 1'b1,
        rxd: 1'b1,
        bus_tx: 1'b1,
        default: '0
    };

    always_comb begin
        lnk_next = lnk_reg;
        lnk_next.standby_select_pin_s1 = standby_select_pin_in;
        lnk_next.standby_select_pin_s2 = lnk_reg.standby_select_pin_s1;
        lnk_next.txd_s1 = ctl_reg.can_tx;
        lnk_next.txd_s2 = lnk_reg.txd_s1;
        lnk_next.bus_s1 = bus_rx_in;
        lnk_next.bus_s2 = lnk_reg.bus_s1;
        if (!lnk_reg.standby_select_pin_s2) begin
            lnk_next.bus_tx = lnk_reg.txd_s2;
            lnk_next.rxd = lnk_reg.bus_s2;
            lnk_next.filt_cnt = 4'h0;
        end else begin
            lnk_next.bus_tx = 1'b1;
            if (lnk_reg.bus_s2) begin
                lnk_next.filt_cnt = 4'h0;
                lnk_next.rxd = 1'b1;
            end else if (lnk_reg.filt_cnt == 4'(WUF_CYC - 1)) begin
                lnk_next.rxd = 1'b0;
            end else begin
                lnk_next.filt_cnt = lnk_reg.filt_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge bus_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lnk_reg <= LNK_RST;
        end else begin
            lnk_reg <= lnk_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign mode_status_out = ctl_reg.status;
    assign osc_enable_out = ctl_reg.osc_en;
    assign wake_flag_out = ctl_reg.wake_flag;
    assign wake_irq_out = ctl_reg.wake_irq;
    assign tec_out = ctl_reg.tec;
    assign rec_out = ctl_reg.rec;
    assign cfg_out = ctl_reg.cfg;
    assign controller_transmit_out = ctl_reg.can_tx;
    assign engine_rx_out = ctl_reg.eng_rx;
    assign ack_enable_out = ctl_reg.ack_en;
    assign err_frame_enable_out = ctl_reg.err_en;
    assign ignore_ack_out = ctl_reg.ign_ack;
    assign rx_store_out = ctl_reg.store;
    assign bus_tx_out = lnk_reg.bus_tx;
    assign rxd_out = lnk_reg.rxd;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    property p_cfg_req;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (mode_request_in == `CNM_MODE_CONFIG && !tx_pending_in &&
         (ctl_reg.mode == cnm_pkg::cnm_md_normal ||
          ctl_reg.mode == cnm_pkg::cnm_md_listen ||
          ctl_reg.mode == cnm_pkg::cnm_md_loop))
        |=> mode_status_out == `CNM_MODE_CONFIG;
    endproperty
    a_cfg_req: assert property (p_cfg_req)
        else $error("config request not honoured");

    property p_cfg_clr;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        ctl_reg.mode == cnm_pkg::cnm_md_config |-> tec_out == 8'h00 &&
            rec_out == 8'h00;
    endproperty
    a_cfg_clr: assert property (p_cfg_clr)
        else $error("error counters not cleared in config");

    property p_cfg_lock;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        ctl_reg.mode != cnm_pkg::cnm_md_config |=> $stable(cfg_out);
    endproperty
    a_cfg_lock: assert property (p_cfg_lock)
        else $error("protected config changed outside config");

    property p_tx_quiet;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        ctl_reg.mode != cnm_pkg::cnm_md_normal |->
            controller_transmit_out && !ack_enable_out &&
            !err_frame_enable_out;
    endproperty
    a_tx_quiet: assert property (p_tx_quiet)
        else $error("transmit activity outside normal mode");

    property p_ost;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        $rose(ctl_reg.mode == cnm_pkg::cnm_md_wake) |->
            ##128 mode_status_out == `CNM_MODE_LISTEN;
    endproperty
    a_ost: assert property (p_ost)
        else $error("start-up interval wrong length");

    property p_wake_irq;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (host_wake_in && wake_interrupt_enable_in) |=> wake_irq_out;
    endproperty
    a_wake_irq: assert property (p_wake_irq)
        else $error("wake interrupt missing");

    property p_defer;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (tx_pending_in && ctl_reg.mode != cnm_pkg::cnm_md_sleep &&
         ctl_reg.mode != cnm_pkg::cnm_md_wake) |=> $stable(mode_status_out);
    endproperty
    a_defer: assert property (p_defer)
        else $error("mode changed with transmission pending");

    property p_listen_cnt;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        mode_status_out == `CNM_MODE_LISTEN |-> tec_out == 8'h00 &&
            rec_out == 8'h00;
    endproperty
    a_listen_cnt: assert property (p_listen_cnt)
        else $error("error counter active in listen-only");

    property p_osc;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        ctl_reg.mode == cnm_pkg::cnm_md_sleep |-> !osc_enable_out;
    endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator running in sleep");

    property p_standby_select_pin_off;
        @(posedge bus_clk_in) disable iff (!arst_n_in)
        lnk_reg.standby_select_pin_s2 |=> bus_tx_out;
    endproperty
    a_standby_select_pin_off: assert property (p_standby_select_pin_off)
        else $error("bus driven in standby");

    property p_norm_rx;
        @(posedge bus_clk_in) disable iff (!arst_n_in)
        !lnk_reg.standby_select_pin_s2 |=> rxd_out == $past(lnk_reg.bus_s2);
    endproperty
    a_norm_rx: assert property (p_norm_rx)
        else $error("rxd not following bus in normal");

    property p_noise;
        @(posedge bus_clk_in) disable iff (!arst_n_in)
        (lnk_reg.standby_select_pin_s2 && lnk_reg.bus_s2) |=> rxd_out;
    endproperty
    a_noise: assert property (p_noise)
        else $error("rxd low without filtered activity");

    c_sleep: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        $rose(ctl_reg.mode == cnm_pkg::cnm_md_sleep));
    c_wake: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        $fell(ctl_reg.mode == cnm_pkg::cnm_md_wake));
    c_loop: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        ignore_ack_out && rx_store_out);
    c_filt: cover property (@(posedge bus_clk_in) disable iff (!arst_n_in)
        lnk_reg.standby_select_pin_s2 && $fell(rxd_out));

endmodule : cnm_mode_manager
`default_nettype wire

// ==== tb/cnm_host_model.sv ====
/*
 Host model: drives the mode request and the standby pin, polls status.
 Assumes the controller clock and changes at its falling edges.
*/
`include "cnm_map.svh"
`default_nettype none
module cnm_host_model (
    input wire logic ref_clk_in,
    input wire logic [2:0] mode_status_in,
    output logic [2:0] mode_request_out,
    output logic standby_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        mode_request_out = `CNM_MODE_CONFIG;
        standby_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // Request a mode, poll status for up to n cycles
    task automatic go(input logic [2:0] code, input logic standby_select_pin,
        input int n, output logic ok);
        @(negedge ref_clk_in);
        standby_out = standby_select_pin;
        mode_request_out = code;
        ok = 1'b0;
        for (int i = 0; i < n && !ok; i++) begin
            @(negedge ref_clk_in);
            ok = (mode_status_in === code);
        end
    endtask : go
endmodule : cnm_host_model
`default_nettype wire

// ==== tb/cnm_tb.sv ====
/*
 Testbench of the CAN node mode manager: host model, bus stimulus, checks.
 Assumes the design and the host model are compiled ahead of it.
*/
`include "cnm_map.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 1'b0, bus_clk_in = 1'b0, arst_n_in = 1'b0;
    logic [2:0] mode_request_in, cfg_sel_in, mode_status_out;
    logic tx_pending_in, host_wake_in, wake_flag_clr_in, ok;
    logic wake_interrupt_enable_in, cfg_wr_in, engine_tx_in;
    logic tec_inc_in, rec_inc_in, frame_done_in, frame_error_in;
    logic standby_select_pin_in, bus_rx_in, osc_enable_out;
    logic wake_flag_out, wake_irq_out, controller_transmit_out;
    logic engine_rx_out, ack_enable_out, err_frame_enable_out;
    logic ignore_ack_out, rx_store_out, bus_tx_out, rxd_out;
    logic [7:0] cfg_data_in, frame_id_in, tec_out, rec_out;
    cnm_pkg::cnm_cfg_s cfg_out;
    int n_mismatch = 0;
    int tests_run = 0;
    always #25 ref_clk_in = ~ref_clk_in;
    always #32 bus_clk_in = ~bus_clk_in;
    cnm_mode_manager dut (.ref_clk_in, .bus_clk_in, .arst_n_in,
        .mode_request_in, .tx_pending_in, .host_wake_in,
        .wake_flag_clr_in, .wake_interrupt_enable_in, .cfg_wr_in,
        .cfg_sel_in, .cfg_data_in, .engine_tx_in, .tec_inc_in,
        .rec_inc_in, .frame_done_in, .frame_error_in, .frame_id_in,
        .standby_select_pin_in, .bus_rx_in, .mode_status_out,
        .osc_enable_out, .wake_flag_out, .wake_irq_out, .tec_out,
        .rec_out, .cfg_out, .controller_transmit_out, .engine_rx_out,
        .ack_enable_out, .err_frame_enable_out, .ignore_ack_out,
        .rx_store_out, .bus_tx_out, .rxd_out);
    cnm_host_model host (.ref_clk_in, .mode_status_in(mode_status_out),
        .mode_request_out(mode_request_in),
        .standby_out(standby_select_pin_in));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic lim(input logic done);
        if (done !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: wait ran out", $time);
            finish_test();
        end
    endtask : lim
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask : cyc
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        cfg_wr_in = 1'b1;
        cfg_sel_in = sel;
        cfg_data_in = d;
        cyc(1);
        cfg_wr_in = 1'b0;
        cyc(1);
    endtask : wr
    task automatic incs();
        tec_inc_in = 1'b1;
        rec_inc_in = 1'b1;
        cyc(1);
        tec_inc_in = 1'b0;
        rec_inc_in = 1'b0;
        cyc(1);
    endtask : incs
    task automatic frm(input logic [7:0] id, input logic err,
        input logic exp);
        logic s;
        s = 1'b0;
        frame_id_in = id;
        frame_error_in = err;
        frame_done_in = 1'b1;
        repeat (2) begin
            cyc(1);
            frame_done_in = 1'b0;
            s |= rx_store_out;
        end
        chk(s, exp);
    endtask : frm
    task automatic wait_mode(input logic [2:0] code, input int n);
        ok = 1'b0;
        for (int i = 0; i < n && !ok; i++) begin
            cyc(1);
            ok = (mode_status_out === code);
        end
        lim(ok);
    endtask : wait_mode
    ////////////////////////////////////////////////////////////
    task automatic t_cfg();
        chk(mode_status_out, `CNM_MODE_CONFIG);
        chk({osc_enable_out, ack_enable_out, tec_out, rec_out},
            18'h20000);
        wr(`CNM_SEL_FILT, 8'h5a);
        wr(`CNM_SEL_MASK, 8'hf0);
        wr(`CNM_SEL_BTA, 8'h3c);
        wr(`CNM_SEL_BTB, 8'h11);
        wr(`CNM_SEL_BTC, 8'h22);
        wr(`CNM_SEL_SEND, 8'h33);
        chk(cfg_out, 48'h3c1122335af0);
        host.go(3'h7, 1'b0, 3, ok);
        chk({ok, mode_status_out}, {1'b0, `CNM_MODE_CONFIG});
    endtask : t_cfg
    task automatic t_normal();
        host.go(`CNM_MODE_NORMAL, 1'b0, 4, ok);
        lim(ok);
        chk({ack_enable_out, err_frame_enable_out}, 2'h3);
        engine_tx_in = 1'b0;
        bus_rx_in = 1'b0;
        cyc(1);
        chk(controller_transmit_out, 1'b0);
        cyc(8);
        chk({bus_tx_out, rxd_out, engine_rx_out}, 3'h0);
        engine_tx_in = 1'b1;
        bus_rx_in = 1'b1;
        wr(`CNM_SEL_FILT, 8'hff);
        chk(cfg_out, 48'h3c1122335af0);
        incs();
        chk({tec_out, rec_out}, 16'h0101);
        host.go(`CNM_MODE_CONFIG, 1'b0, 4, ok);
        lim(ok);
        chk({tec_out, rec_out}, 16'h0000);
        host.go(`CNM_MODE_NORMAL, 1'b0, 4, ok);
        lim(ok);
        tx_pending_in = 1'b1;
        host.go(`CNM_MODE_LISTEN, 1'b0, 4, ok);
        chk({ok, mode_status_out}, {1'b0, `CNM_MODE_NORMAL});
        tx_pending_in = 1'b0;
        cyc(1);
        chk(mode_status_out, `CNM_MODE_LISTEN);
    endtask : t_normal
    task automatic t_silent();
        engine_tx_in = 1'b0;
        incs();
        chk({controller_transmit_out, ack_enable_out, err_frame_enable_out},
            3'h4);
        chk({tec_out, rec_out}, 16'h0000);
        frm(8'ha3, 1'b1, 1'b1);
        host.go(`CNM_MODE_LOOP, 1'b0, 4, ok);
        lim(ok);
        chk({controller_transmit_out, ignore_ack_out, engine_rx_out},
            3'h6);
        engine_tx_in = 1'b1;
        frm(8'h53, 1'b0, 1'b1);
        frm(8'ha3, 1'b0, 1'b0);
        host.go(`CNM_MODE_CONFIG, 1'b0, 4, ok);
        lim(ok);
        wr(`CNM_SEL_MASK, 8'h00);
        host.go(`CNM_MODE_LOOP, 1'b0, 4, ok);
        lim(ok);
        frm(8'ha3, 1'b0, 1'b1);
    endtask : t_silent
    task automatic t_host_wake();
        wake_interrupt_enable_in = 1'b1;
        host.go(`CNM_MODE_SLEEP, 1'b0, 4, ok);
        lim(ok);
        chk(osc_enable_out, 1'b0);
        host_wake_in = 1'b1;
        cyc(1);
        host_wake_in = 1'b0;
        chk({osc_enable_out, wake_flag_out, wake_irq_out, mode_status_out},
            {3'h7, `CNM_MODE_SLEEP});
        cyc(`CNM_OST_CYC - 2);
        chk(mode_status_out, `CNM_MODE_SLEEP);
        wait_mode(`CNM_MODE_LISTEN, 4);
        wake_flag_clr_in = 1'b1;
        cyc(1);
        wake_flag_clr_in = 1'b0;
        cyc(1);
        chk({wake_flag_out, wake_irq_out}, 2'h0);
    endtask : t_host_wake
    task automatic t_bus_wake();
        wake_interrupt_enable_in = 1'b0;
        host.go(`CNM_MODE_NORMAL, 1'b1, 4, ok);
        lim(ok);
        engine_tx_in = 1'b0;
        cyc(8);
        chk(bus_tx_out, 1'b1);
        engine_tx_in = 1'b1;
        host.go(`CNM_MODE_SLEEP, 1'b1, 4, ok);
        lim(ok);
        bus_rx_in = 1'b0;
        cyc(4);
        bus_rx_in = 1'b1;
        ok = 1'b1;
        repeat (12) begin
            cyc(1);
            ok &= rxd_out;
        end
        chk({ok, mode_status_out}, {1'b1, `CNM_MODE_SLEEP});
        bus_rx_in = 1'b0;
        cyc(4);
        chk(rxd_out, 1'b1);
        ok = 1'b0;
        for (int i = 0; i < 30 && !ok; i++) begin
            cyc(1);
            ok = (rxd_out === 1'b0);
        end
        lim(ok);
        cyc(6);
        chk({wake_flag_out, wake_irq_out, osc_enable_out},
            3'h5);
        bus_rx_in = 1'b1;
        wait_mode(`CNM_MODE_LISTEN, 140);
        frm(8'ha3, 1'b1, 1'b0);
        frm(8'ha3, 1'b1, 1'b1);
        host.go(`CNM_MODE_NORMAL, 1'b0, 4, ok);
        lim(ok);
    endtask : t_bus_wake
    ////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    initial begin
        {tx_pending_in, host_wake_in, wake_flag_clr_in, cfg_wr_in} = 4'h0;
        {wake_interrupt_enable_in, tec_inc_in, rec_inc_in} = 3'h0;
        {frame_done_in, frame_error_in, cfg_sel_in} = 5'h00;
        {cfg_data_in, frame_id_in} = 16'h0000;
        engine_tx_in = 1'b1;
        bus_rx_in = 1'b1;
        cyc(5);
        arst_n_in = 1'b1;
        cyc(1);
        t_cfg();
        t_normal();
        t_silent();
        t_host_wake();
        t_bus_wake();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
